// ===== hdl/rtc_map.vh
// register offsets, field positions, reset values and timing figures of the output-pin block
`ifndef RTC_MAP_VH
`define RTC_MAP_VH

// =====================================================================
// register offsets
`define RTC_OFS_CONTROL       8'h0E
`define RTC_OFS_STATUS        8'h0F

// =====================================================================
// output_control_reg fields
`define RTC_CTL_ALARM1_EN     0
`define RTC_CTL_ALARM2_EN     1
`define RTC_CTL_IRQ_MODE_SEL  2
`define RTC_CTL_OSC_DISABLE   7
`define RTC_CTL_RESET_VAL     8'h04

// =====================================================================
// flag_status_reg fields
`define RTC_STA_ALARM1_FLAG   0
`define RTC_STA_ALARM2_FLAG   1
`define RTC_STA_RESET_ACTIVE  2
`define RTC_STA_CLK_OUT_EN    3
`define RTC_STA_RESET_VAL     8'h08

// =====================================================================
// timing: oscillator tick rate is twice the clock-output frequency
`define RTC_CLK_OUT_HZ        32768
`define RTC_OSC_TICK_HZ       (2 * `RTC_CLK_OUT_HZ)
`define RTC_SQW_HZ            1
`define RTC_T_RST_MS          250
`define RTC_T_DEBOUNCE_MS     250
`define RTC_RST_TICKS         ((`RTC_T_RST_MS * `RTC_OSC_TICK_HZ) / 1000)
`define RTC_DEBOUNCE_TICKS    ((`RTC_T_DEBOUNCE_MS * `RTC_OSC_TICK_HZ) / 1000)
`define RTC_SQW_HALF_TICKS    (`RTC_OSC_TICK_HZ / (2 * `RTC_SQW_HZ))

`endif

// ===== hdl/rtc_tick_timer.v
// saturating counter of oscillator ticks with a reach flag
module rtc_tick_timer
#(
  parameter LIMIT = 16384
)
(
  input  wire mclk,
  input  wire rstn,
  input  wire clr,
  input  wire tick,
  output wire done
);

  localparam CW = $clog2(LIMIT + 1);
  localparam [CW-1:0] LIM = LIMIT[CW-1:0];

  reg [CW-1:0] cnt_reg;
  reg [CW-1:0] cnt_next;

  // =====================================================================
  // counting stops at the limit so done stays high until cleared
  always @*
  begin
    cnt_next = cnt_reg;
    if (clr)
      cnt_next = {CW{1'b0}};
    else if (tick && cnt_reg != LIM)
      cnt_next = cnt_reg + {{(CW-1){1'b0}}, 1'b1};
  end

  always @(posedge mclk)
  begin
    if (!rstn)
      cnt_reg <= {CW{1'b0}};
    else
      cnt_reg <= cnt_next;
  end

  assign done = (cnt_reg == LIM);

endmodule // rtc_tick_timer

// ===== hdl/rtc_out_pins.v
// clock output, interrupt/square-wave pin and reset supervisor of the real-time clock
//
// Functional notes
// - the clock pin carries a 32.768kHz 50% duty square wave by pulling low or releasing.
// - the clock pin toggles only while the clock-output enable bit of the status register is set.
// - with irq mode select at 0 the shared pin carries a 1Hz square wave.
// - with irq mode select at 1 the shared pin goes low on an enabled alarm match.
// - irq mode select resets to 1 with both alarms disabled.
// - the reset pin is driven low while the primary supply is below threshold.
// - after the supply returns and holds for the reset active time the pin is released.
// - the reset pin is also a pushbutton input, debounced before reset is asserted.
// - with the oscillator disabled the recovery delay is skipped and reset releases at once.
// - the oscillator counts as disabled when its disable bit is 1.
// - the reset pin never affects register access or timekeeping.
`include "rtc_map.vh"

module rtc_out_pins
#(
  parameter RST_TICKS  = `RTC_RST_TICKS,
  parameter DB_TICKS   = `RTC_DEBOUNCE_TICKS,
  parameter SQW_TICKS  = `RTC_SQW_HALF_TICKS
)
(
  input  wire       mclk,
  input  wire       rstn,
  input  wire       osc_tick,
  input  wire       vcc_above_threshold,
  input  wire       alarm1_match,
  input  wire       alarm2_match,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_we,
  output reg  [7:0] reg_rdata,
  output wire       osc_clock_out_o,
  output reg        osc_clock_out_oe,
  output wire       irq_or_square_wave_out_o,
  output reg        irq_or_square_wave_out_oe,
  input  wire       rst_pin_i,
  output wire       rst_pin_o,
  output wire       rst_pin_oe
);

  // supervisor states
  localparam [2:0] ST_RUN  = 3'b001;
  localparam [2:0] ST_FAIL = 3'b010;
  localparam [2:0] ST_HOLD = 3'b100;
  // status reset image, so single fields can be picked out of it
  localparam [7:0] STA_RESET = `RTC_STA_RESET_VAL;

  reg  [7:0] ctrl_reg;
  reg  [7:0] ctrl_next;
  reg  [1:0] flag_reg;
  reg  [1:0] flag_next;
  reg        clk_en_reg;
  reg        clk_phase_reg;
  reg        sqw_reg;
  reg  [2:0] state_reg;
  reg  [2:0] state_next;
  reg        wait_release_reg;
  wire       sqw_done;
  wire       db_done;
  wire       hold_done;
  wire       osc_off;
  wire       press_low;
  wire       pressed;
  wire [1:0] alarm_hit;

  // a decode used for both register writes and readback
  function sel;
    input [7:0] a;
    input [7:0] ofs;
    begin
      sel = (a == ofs);
    end
  endfunction

  // =====================================================================
  // registers; nothing here is reset by the reset pin, only by rstn
  assign osc_off = ctrl_reg[`RTC_CTL_OSC_DISABLE];
  assign alarm_hit = {alarm2_match, alarm1_match};

  always @*
  begin
    ctrl_next = ctrl_reg;
    if (reg_we && sel(reg_addr, `RTC_OFS_CONTROL))
      ctrl_next = reg_wdata & 8'h87;
  end

  // flags: a match in the same cycle as a clearing write keeps the flag set
  always @*
  begin
    flag_next = flag_reg;
    if (reg_we && sel(reg_addr, `RTC_OFS_STATUS))
      flag_next = flag_reg & reg_wdata[1:0];
    flag_next = flag_next | alarm_hit;
  end

  always @(posedge mclk)
  begin
    if (!rstn)
    begin
      ctrl_reg   <= `RTC_CTL_RESET_VAL;
      flag_reg   <= 2'h0;
      clk_en_reg <= STA_RESET[`RTC_STA_CLK_OUT_EN];
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      flag_reg <= flag_next;
      if (reg_we && sel(reg_addr, `RTC_OFS_STATUS))
        clk_en_reg <= reg_wdata[`RTC_STA_CLK_OUT_EN];
    end
  end

  // readback is registered; unmapped offsets read zero
  always @(posedge mclk)
  begin
    if (!rstn)
      reg_rdata <= 8'h00;
    else if (sel(reg_addr, `RTC_OFS_CONTROL))
      reg_rdata <= ctrl_reg;
    else if (sel(reg_addr, `RTC_OFS_STATUS))
      reg_rdata <= {4'h0, clk_en_reg, rst_pin_oe, flag_reg};
    else
      reg_rdata <= 8'h00;
  end

  // =====================================================================
  // clock output and 1Hz square wave, both derived from the oscillator tick
  rtc_tick_timer #(.LIMIT(SQW_TICKS)) u_sqw
  (
    .mclk (mclk),
    .rstn (rstn),
    .clr  (sqw_done),
    .tick (osc_tick),
    .done (sqw_done)
  );

  // the phase flips on every tick so high and low halves are equal
  always @(posedge mclk)
  begin
    if (!rstn)
    begin
      clk_phase_reg <= 1'b1;
      sqw_reg       <= 1'b1;
    end
    else
    begin
      if (osc_tick)
        clk_phase_reg <= ~clk_phase_reg;
      if (sqw_done)
        sqw_reg <= ~sqw_reg;
    end
  end

  // open-drain drivers: enables are registered so pins never glitch
  always @(posedge mclk)
  begin
    if (!rstn)
    begin
      osc_clock_out_oe          <= 1'b0;
      irq_or_square_wave_out_oe <= 1'b0;
    end
    else
    begin
      osc_clock_out_oe <= clk_en_reg & ~clk_phase_reg;
      if (ctrl_reg[`RTC_CTL_IRQ_MODE_SEL])
        irq_or_square_wave_out_oe <= |(flag_reg & ctrl_reg[1:0]);
      else
        irq_or_square_wave_out_oe <= ~sqw_reg;
    end
  end

  assign osc_clock_out_o          = 1'b0;
  assign irq_or_square_wave_out_o = 1'b0;

  // =====================================================================
  // pushbutton: the pin low while we are not driving it is a press request
  assign press_low = ~rst_pin_i & ~rst_pin_oe;

  rtc_tick_timer #(.LIMIT(DB_TICKS)) u_debounce
  (
    .mclk (mclk),
    .rstn (rstn),
    .clr  (~press_low),
    .tick (osc_tick),
    .done (db_done)
  );

  // one press gives one reset; the button must be let go before the next
  assign pressed = db_done & ~wait_release_reg;

  always @(posedge mclk)
  begin
    if (!rstn)
      wait_release_reg <= 1'b0;
    else if (pressed)
      wait_release_reg <= 1'b1;
    else if (rst_pin_i && !rst_pin_oe)
      wait_release_reg <= 1'b0;
  end

  // =====================================================================
  // reset supervisor
  rtc_tick_timer #(.LIMIT(RST_TICKS)) u_hold
  (
    .mclk (mclk),
    .rstn (rstn),
    .clr  (state_reg != ST_HOLD),
    .tick (osc_tick),
    .done (hold_done)
  );

  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN:
      begin
        if (!vcc_above_threshold)
          state_next = ST_FAIL;
        else if (pressed)
          state_next = ST_HOLD;
      end
      ST_FAIL:
      begin
        if (vcc_above_threshold)
          state_next = osc_off ? ST_RUN : ST_HOLD;
      end
      ST_HOLD:
      begin
        if (!vcc_above_threshold)
          state_next = ST_FAIL;
        else if (hold_done)
          state_next = ST_RUN;
      end
      default:
        state_next = ST_FAIL;
    endcase
  end

  // start asserted: the supply is not yet known good
  always @(posedge mclk)
  begin
    if (!rstn)
      state_reg <= ST_FAIL;
    else
      state_reg <= state_next;
  end

  // released pin is raised by the internal pullup only
  assign rst_pin_oe = (state_reg != ST_RUN);
  assign rst_pin_o  = 1'b0;
  // the reset pin reaches no register or timer above except the pushbutton debounce, its release latch and the supervisor

endmodule // rtc_out_pins

// ===== testbench/rtc_host_model.sv
// board side of the pins: pullups, pushbutton and resolved line levels
module rtc_host_model
(
  input  wire clk_oe,
  input  wire irq_oe,
  input  wire rst_oe,
  input  wire press,
  output wire clk_line,
  output wire irq_line,
  output wire rst_line
);
  timeunit 1ns;
  timeprecision 1ns;
  // =========================================================
  // wired levels; no board pullup on reset, the internal one raises it
  assign clk_line = !clk_oe;
  assign irq_line = !irq_oe;
  assign rst_line = !(rst_oe || press);
endmodule // rtc_host_model

// ===== testbench/rtc_out_pins_monitor.sv
// assertions and covers on the pins and register readback of the output-pin block
module rtc_out_pins_monitor
(
  input wire       mclk,
  input wire       rstn,
  input wire       osc_tick,
  input wire       vcc_above_threshold,
  input wire       alarm1_match,
  input wire       alarm2_match,
  input wire [7:0] reg_addr,
  input wire       reg_we,
  input wire [7:0] reg_rdata,
  input wire       osc_clock_out_o,
  input wire       osc_clock_out_oe,
  input wire       irq_or_square_wave_out_o,
  input wire       irq_or_square_wave_out_oe,
  input wire       rst_pin_i,
  input wire       rst_pin_o,
  input wire       rst_pin_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // =========================================================
  // recent causes; a pin that moves with none of them is spurious
  reg [3:0] evh;
  always @(posedge mclk)
    evh <= {evh[2:0], osc_tick | reg_we | alarm1_match | alarm2_match | !rstn};
  // =========================================================
  property p_pins_low; !osc_clock_out_o && !irq_or_square_wave_out_o && !rst_pin_o; endproperty
  a_pins_low: assert property (p_pins_low) else $error("pin driven high");
  property p_clk; $changed(osc_clock_out_oe) |-> |evh; endproperty
  a_clk: assert property (p_clk) else $error("clock pin moved without tick");
  property p_irq; $changed(irq_or_square_wave_out_oe) |-> |evh; endproperty
  a_irq: assert property (p_irq) else $error("irq pin moved without cause");
  property p_vfail; !vcc_above_threshold |=> rst_pin_oe; endproperty
  a_vfail: assert property (p_vfail) else $error("reset not driven on fail");
  property p_rel; $fell(rst_pin_oe) |-> $past(vcc_above_threshold); endproperty
  a_rel: assert property (p_rel) else $error("reset released without supply");
  property p_press;
    $rose(rst_pin_oe) |-> !$past(vcc_above_threshold) || !$past(rst_pin_i, 2)
      || !$past(rst_pin_i, 3);
  endproperty
  a_press: assert property (p_press) else $error("reset without cause");
  property p_hold; $rose(rst_pin_oe) && $past(vcc_above_threshold) |=> rst_pin_oe [*3];
  endproperty
  a_hold: assert property (p_hold) else $error("press reset too short");
  property p_unmap; !($past(reg_addr) inside {8'h0E, 8'h0F}) |-> reg_rdata == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  // =========================================================
  c_press: cover property ($rose(rst_pin_oe) && $past(vcc_above_threshold));
  c_alarm: cover property (alarm1_match ##2 irq_or_square_wave_out_oe);
  c_clk: cover property ($fell(osc_clock_out_oe));
endmodule // rtc_out_pins_monitor

bind rtc_out_pins rtc_out_pins_monitor mon (.*);

// ===== testbench/rtc_out_pins_bench.sv
// self-checking bench for the output-pin block
module rtc_out_pins_bench;
  timeunit 1ns;
  timeprecision 1ns;
  reg        mclk = 0, rstn = 0, osc_tick = 0, vcc = 1, al1 = 0, al2 = 0, we = 0, press = 0;
  reg  [7:0] addr = 8'h00, wd = 8'h00;
  reg  [1:0] tc = 2'h0;
  wire [7:0] rd;
  wire       c_oe, i_oe, r_oe, c_l, i_l, r_l;
  wire [3:0] ln = {r_oe, r_l, i_l, c_l};
  int        failures = 0, n_tests = 0, cyc = 0;
  // four-state counts, so an unknown line level cannot pass as zero
  reg  [7:0] lo, fa;
  always #10 mclk = ~mclk;
  // oscillator tick every fourth cycle keeps the short counts quick
  always @(negedge mclk)
  begin
    tc <= tc + 2'h1;
    osc_tick <= (tc == 2'h3);
  end
  rtc_out_pins #(.RST_TICKS(4), .DB_TICKS(4), .SQW_TICKS(8)) uut
  (
    .mclk(mclk), .rstn(rstn), .osc_tick(osc_tick), .vcc_above_threshold(vcc),
    .alarm1_match(al1), .alarm2_match(al2), .reg_addr(addr), .reg_wdata(wd),
    .reg_we(we), .reg_rdata(rd), .osc_clock_out_o(), .osc_clock_out_oe(c_oe),
    .irq_or_square_wave_out_o(), .irq_or_square_wave_out_oe(i_oe),
    .rst_pin_i(r_l), .rst_pin_o(), .rst_pin_oe(r_oe)
  );
  rtc_host_model host (.clk_oe(c_oe), .irq_oe(i_oe), .rst_oe(r_oe), .press(press),
    .clk_line(c_l), .irq_line(i_l), .rst_line(r_l));
  // =========================================================
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task rng(input string nm, input logic [7:0] v, input int l, input int h);
    chk(nm, 8'(v >= l && v <= h), 8'h01);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    addr = a;
    wd = d;
    we = 1;
    @(negedge mclk);
    we = 0;
  endtask
  task rdc(input logic [7:0] a, input logic [7:0] e, input string nm);
    @(negedge mclk);
    addr = a;
    @(negedge mclk);
    chk(nm, rd, e);
  endtask
  // count low samples and falling edges of one line
  task obs(input int c, input int s);
    logic pv;
    pv = ln[s];
    lo = 8'h00;
    fa = 8'h00;
    repeat (c)
    begin
      @(negedge mclk);
      lo += !ln[s];
      fa += (pv && !ln[s]);
      pv = ln[s];
    end
  endtask
  task end_sim;
    if (failures == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // hang guard
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      failures++;
      end_sim;
    end
  end
  // =========================================================
  initial
  begin
    repeat (10) @(negedge mclk);
    rstn = 1;
    chk("rst_oe", 8'(r_oe), 8'h01);
    rdc(8'h0E, 8'h04, "ctl");
    rdc(8'h0F, 8'h0C, "sta");
    obs(30, 0);
    chk("rst_rel", 8'(r_oe), 8'h01 ^ 8'h01);
    obs(64, 0);
    chk("clk_lo", 8'(lo), 8'h20);
    chk("clk_fa", 8'(fa), 8'h08);
    wr(8'h0F, 8'h00);
    obs(4, 0);
    obs(64, 0);
    chk("clk_off", 8'(lo), 8'h00);
    wr(8'h0E, 8'h05);
    al2 = 1;
    @(negedge mclk);
    al2 = 0;
    obs(4, 1);
    chk("al2_off", 8'(lo), 8'h00);
    al1 = 1;
    @(negedge mclk);
    al1 = 0;
    obs(4, 1);
    chk("al1_irq", 8'(lo), 8'h04);
    rdc(8'h0F, 8'h03, "flags");
    wr(8'h0F, 8'h00);
    obs(4, 1);
    chk("irq_clr", 8'(lo), 8'h00);
    wr(8'h0E, 8'h06);
    al2 = 1;
    @(negedge mclk);
    al2 = 0;
    obs(4, 1);
    chk("al2_irq", 8'(lo), 8'h04);
    // a match in the same cycle as a clearing write must leave the flag set
    fork
      wr(8'h0F, 8'h00);
      begin
        @(negedge mclk);
        al2 = 1;
        @(negedge mclk);
        al2 = 0;
      end
    join
    rdc(8'h0F, 8'h02, "set_wins");
    wr(8'h0F, 8'h00);
    wr(8'h0E, 8'h00);
    obs(80, 1);
    obs(128, 1);
    rng("sqw", lo, 60, 68);
    wr(8'h0E, 8'h04);
    vcc = 0;
    obs(6, 2);
    chk("vfail", 8'(lo), 8'h06);
    vcc = 1;
    obs(40, 2);
    rng("trst", lo, 13, 20);
    wr(8'h0E, 8'hFD);
    rdc(8'h0E, 8'h85, "ctl_ro");
    wr(8'h3A, 8'hFF);
    rdc(8'h3A, 8'h00, "unmap");
    vcc = 0;
    obs(6, 2);
    vcc = 1;
    obs(10, 2);
    rng("osc_off", lo, 0, 2);
    wr(8'h0E, 8'h04);
    press = 1;
    fork
      obs(30, 3);
      repeat (8) @(negedge mclk);
    join_any
    press = 0;
    wait fork;
    chk("bounce", 8'(lo), 8'h1E);
    press = 1;
    fork
      obs(80, 3);
      repeat (30) @(negedge mclk);
    join_any
    press = 0;
    wait fork;
    rng("press", 8'(80 - lo), 13, 20);
    end_sim;
  end
endmodule // rtc_out_pins_bench
